// >>> rtl/ubsc_params.svh
// Offsets, field positions, reset values and timing counts of the serial rate and control block.
`ifndef UBSC_PARAMS_SVH
`define UBSC_PARAMS_SVH
`define UBSC_ADDR_SERIAL_CTRL 8'h98
`define UBSC_ADDR_RATE_RELOAD 8'h9A
`define UBSC_ADDR_RATE_CTRL 8'h9B
`define UBSC_ADDR_SRC_SEL 8'h9C
`define UBSC_ADDR_POWER_CTRL 8'h87
`define UBSC_ADDR_TX_DATA 8'h99
`define UBSC_RST_BYTE 8'h00
`define UBSC_SC_TOP 7
`define UBSC_SC_MODE_LO 6
`define UBSC_SC_MULTI 5
`define UBSC_SC_RX_EN 4
`define UBSC_SC_TX9 3
`define UBSC_SC_RX9 2
`define UBSC_SC_TX_DONE 1
`define UBSC_SC_RX_DONE 0
`define UBSC_RC_TX_BRG 3
`define UBSC_RC_RX_BRG 2
`define UBSC_RC_SPEED 1
`define UBSC_RC_SHIFT_BRG 0
`define UBSC_SS_TX_T2 1
`define UBSC_SS_RX_T2 0
`define UBSC_PC_DOUBLER 7
`define UBSC_PC_FE_SEL 6
`define UBSC_BRG_TOP 8'hFF
`define UBSC_SLOW_PRESCALE 4'hB
`define UBSC_FAST_PRESCALE 4'h1
`define UBSC_OVS_LAST 4'hF
`define UBSC_SHIFT_DIV 3'h5
`define UBSC_M2_DIV 5'h01
`define UBSC_M2_DIV_DBL 5'h00
`define UBSC_FAST_TICK_DIV 1'b1
`endif

// >>> rtl/ubsc_pkg.sv
// Types shared by the serial rate and control block.
package ubsc_pkg;
  typedef enum logic [1:0] {
    UBSC_MODE_SHIFT = 2'h0,
    UBSC_MODE_UART8 = 2'h1,
    UBSC_MODE_UART9F = 2'h2,
    UBSC_MODE_UART9V = 2'h3
  } ubsc_mode_t;
  typedef enum logic [1:0] {
    UBSC_SRC_T1 = 2'h0,
    UBSC_SRC_T2 = 2'h1,
    UBSC_SRC_BRG = 2'h3
  } ubsc_src_t;
  typedef enum logic [1:0] {
    UBSC_ST_IDLE = 2'h0,
    UBSC_ST_START = 2'h1,
    UBSC_ST_DATA = 2'h3,
    UBSC_ST_STOP = 2'h2
  } ubsc_state_t;
endpackage : ubsc_pkg

// >>> rtl/ubsc_rate_if.sv
// Rate selection carrier between the control top and the rate generator.
`timescale 1ns/1ps
interface ubsc_rate_if;
  logic [7:0] reloadValue;
  logic speedSel;
  logic doubler;
  logic brgTick;
  modport gen (input reloadValue, input speedSel, input doubler, output brgTick);
  modport ctl (output reloadValue, output speedSel, output doubler, input brgTick);
endinterface : ubsc_rate_if

// >>> rtl/ubsc_brg.sv
// Internal reload-based bit-rate generator.
`timescale 1ns/1ps
`include "ubsc_params.svh"
module ubsc_brg import ubsc_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  ubsc_rate_if.gen rate
);
  // Prescale by 2*2*6 in slow speed or 2*2 in fast; the doubler skips the last halving.
  // The wrap compare is a bound, so a speed change never leaves the counter running long.
  logic [3:0] preCnt_r;
  logic halfTog_r;
  logic [7:0] brgCnt_r;
  logic tick_r;
  wire preWrap = (preCnt_r >= (rate.speedSel ? `UBSC_FAST_PRESCALE : `UBSC_SLOW_PRESCALE));
  wire preTick = preWrap && (rate.doubler || halfTog_r);
  wire brgOvf = preTick && (brgCnt_r == `UBSC_BRG_TOP);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      preCnt_r <= 4'h0;
      halfTog_r <= 1'b0;
      brgCnt_r <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      preCnt_r <= preWrap ? 4'h0 : preCnt_r + 4'h1;
      if (preWrap) begin
        halfTog_r <= ~halfTog_r;
      end
      if (brgOvf) begin
        brgCnt_r <= rate.reloadValue;
      end else if (preTick) begin
        brgCnt_r <= brgCnt_r + 8'h01;
      end
      tick_r <= brgOvf;
    end
  end
  assign rate.brgTick = tick_r;
  a_brg_reload: assert property (@(posedge clk) disable iff (!arst_n)
    brgOvf |=> brgCnt_r == $past(rate.reloadValue)) else $error("reload missed");
endmodule : ubsc_brg

// >>> rtl/ubsc_top.sv
// Serial rate selection, control register and serial engines.
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "ubsc_params.svh"
module ubsc_top import ubsc_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  input wire logic timer1Ovf,
  input wire logic timer2Ovf,
  input wire logic rxdPin,
  output logic txdOut,
  output logic shiftClkOut,
  output logic timer2ForceReload
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic modeHi_r, modeLo_r, multi_r, rxEn_r, tx9_r, rx9_r, txDone_r, rxDone_r, fe_r;
  logic [7:0] reload_r;
  logic txBrg_r, rxBrg_r, speed_r, shiftBrg_r, txT2_r, rxT2_r, doubler_r, feSel_r;
  logic [7:0] txData_r;
  logic [7:0] rdData_r;
  ubsc_rate_if rate ();
  assign rate.reloadValue = reload_r;
  assign rate.speedSel = speed_r;
  assign rate.doubler = doubler_r;
  ubsc_brg u_brg (
    .clk(clk),
    .arst_n(arst_n),
    .rate(rate)
  );
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction : hit
  wire wrSc = regWrStb && hit(regAddr, `UBSC_ADDR_SERIAL_CTRL);
  wire wrTx = regWrStb && hit(regAddr, `UBSC_ADDR_TX_DATA);
  ubsc_mode_t mode;
  assign mode = ubsc_mode_t'({modeHi_r, modeLo_r});
  // ----------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------
  ubsc_src_t txSrc, rxSrc;
  assign txSrc = txBrg_r ? UBSC_SRC_BRG : (txT2_r ? UBSC_SRC_T2 : UBSC_SRC_T1);
  assign rxSrc = rxBrg_r ? UBSC_SRC_BRG : (rxT2_r ? UBSC_SRC_T2 : UBSC_SRC_T1);
  // Timer overflows come from logic on this clock, so no synchroniser is needed.
  function automatic logic srcTick(input ubsc_src_t s, input logic t1, input logic t2,
                                   input logic b);
    case (s)
      UBSC_SRC_BRG: return b;
      UBSC_SRC_T2: return t2;
      default: return t1;
    endcase
  endfunction : srcTick
  // Timer 1 and generator rates are halved unless the doubler is set; timer 2 is not.
  logic t1Half_r;
  wire t1Tick = timer1Ovf && (doubler_r || t1Half_r);
  wire txVarTick = srcTick(txSrc, t1Tick, timer2Ovf, rate.brgTick);
  wire rxVarTick = srcTick(rxSrc, t1Tick, timer2Ovf, rate.brgTick);
  logic [2:0] shDiv_r;
  logic [4:0] m2Div_r;
  wire shFixTick = (shDiv_r == `UBSC_SHIFT_DIV);
  wire m2Tick = (m2Div_r >= (doubler_r ? `UBSC_M2_DIV_DBL : `UBSC_M2_DIV));
  wire shTick = shiftBrg_r ? rate.brgTick : shFixTick;
  // Modes 1..3 use 16x oversampling; mode 2 tick is already at bit/16 spacing.
  wire txOvs = (mode == UBSC_MODE_UART9F) ? m2Tick : txVarTick;
  wire rxOvs = (mode == UBSC_MODE_UART9F) ? m2Tick : rxVarTick;
  logic timer2Fr_r;
  assign timer2ForceReload = timer2Fr_r;
  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  ubsc_state_t txSt_r;
  logic [3:0] txOvs_r, txBit_r;
  logic [8:0] txSh_r;
  logic txd_r;
  wire isShift = (mode == UBSC_MODE_SHIFT);
  wire nineBit = mode[1];
  wire [3:0] lastData = nineBit ? 4'h8 : 4'h7;
  wire txBitEnd = isShift ? shTick : (txOvs && txOvs_r == `UBSC_OVS_LAST);
  wire txSetDone = (txSt_r == UBSC_ST_DATA) && txBitEnd && (txBit_r == lastData)
                   && !isShift; // start of stop bit
  wire txSetDone0 = isShift && (txSt_r == UBSC_ST_DATA) && txBitEnd
                    && (txBit_r == 4'h7);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txSt_r <= UBSC_ST_IDLE;
      txOvs_r <= 4'h0;
      txBit_r <= 4'h0;
      txSh_r <= 9'h000;
      txd_r <= 1'b1;
    end else begin
      if (txOvs) begin
        txOvs_r <= txOvs_r + 4'h1;
      end
      case (txSt_r)
        UBSC_ST_IDLE: begin
          if (wrTx) begin
            txSh_r <= {tx9_r, regWrData};
            txSt_r <= isShift ? UBSC_ST_DATA : UBSC_ST_START;
            txBit_r <= 4'h0;
            txOvs_r <= 4'h0;
            txd_r <= isShift ? regWrData[0] : 1'b0;
          end
        end
        UBSC_ST_START: if (txBitEnd) begin
          txSt_r <= UBSC_ST_DATA;
          txd_r <= txSh_r[0];
        end
        UBSC_ST_DATA: if (txBitEnd) begin
          if (txBit_r == (isShift ? 4'h7 : lastData)) begin
            txSt_r <= isShift ? UBSC_ST_IDLE : UBSC_ST_STOP;
            txd_r <= 1'b1;
          end else begin
            txBit_r <= txBit_r + 4'h1;
            txSh_r <= {1'b0, txSh_r[8:1]};
            txd_r <= txSh_r[1];
          end
        end
        UBSC_ST_STOP: if (txBitEnd) begin
          txSt_r <= UBSC_ST_IDLE;
        end
        default: txSt_r <= UBSC_ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  logic rxS1_r, rxS2_r, rxPrev_r;
  ubsc_state_t rxSt_r;
  logic [3:0] rxOvs_r, rxBit_r;
  logic [8:0] rxSh_r;
  wire rxMid = rxOvs && (rxOvs_r == 4'h7);
  wire rxStartEdge = rxPrev_r && !rxS2_r;
  wire rxStopSample = (rxSt_r == UBSC_ST_STOP) && rxMid;
  wire multiOn = multi_r && !isShift;
  // Mode 0 reception is in the shift phase: eight samples on the shift clock.
  wire rx0Done = isShift && (rxSt_r == UBSC_ST_DATA) && shTick && (rxBit_r == 4'h7);
  // With frame error detection on, or multiprocessor mode set in mode 1, done waits for the stop sample.
  // At the last data sample the ninth bit is still on the synchroniser, not in the shifter.
  wire rxLastData = (rxSt_r == UBSC_ST_DATA) && rxMid && (rxBit_r == lastData) && !isShift;
  wire rxAtStop = feSel_r || (multiOn && !nineBit);
  wire rxKeyBit = (rxStopSample && nineBit) ? rxSh_r[8] : rxS2_r;
  wire rxFrameOk = !multiOn || rxKeyBit;
  wire rxSetDone = rx0Done || ((rxAtStop ? rxStopSample : rxLastData) && rxFrameOk);
  wire rxBadStop = rxStopSample && !rxS2_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxS1_r <= 1'b1;
      rxS2_r <= 1'b1;
      rxPrev_r <= 1'b1;
      rxSt_r <= UBSC_ST_IDLE;
      rxOvs_r <= 4'h0;
      rxBit_r <= 4'h0;
      rxSh_r <= 9'h000;
    end else begin
      rxS1_r <= rxdPin;
      rxS2_r <= rxS1_r;
      rxPrev_r <= rxS2_r;
      if (rxOvs) begin
        rxOvs_r <= rxOvs_r + 4'h1;
      end
      case (rxSt_r)
        UBSC_ST_IDLE: begin
          if (rxEn_r && (isShift ? !rxDone_r : rxStartEdge)) begin
            rxSt_r <= isShift ? UBSC_ST_DATA : UBSC_ST_START;
            rxOvs_r <= 4'h0;
            rxBit_r <= 4'h0;
          end
        end
        UBSC_ST_START: if (rxMid) begin
          rxSt_r <= rxS2_r ? UBSC_ST_IDLE : UBSC_ST_DATA;
        end
        UBSC_ST_DATA: begin
          if (!rxEn_r) begin
            rxSt_r <= UBSC_ST_IDLE;
          end else if (isShift ? shTick : rxMid) begin
            rxSh_r <= nineBit ? {rxS2_r, rxSh_r[8:1]} : {1'b0, rxS2_r, rxSh_r[7:1]};
            if (rxBit_r == (isShift ? 4'h7 : lastData)) begin
              rxSt_r <= isShift ? UBSC_ST_IDLE : UBSC_ST_STOP;
            end else begin
              rxBit_r <= rxBit_r + 4'h1;
            end
          end
        end
        UBSC_ST_STOP: if (rxMid) begin
          rxSt_r <= UBSC_ST_IDLE;
        end
        default: rxSt_r <= UBSC_ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Dividers and register file
  // ----------------------------------------------------------------
  wire [7:0] scRead = {feSel_r ? fe_r : modeHi_r, modeLo_r, multi_r, rxEn_r, tx9_r, rx9_r,
                       txDone_r, rxDone_r};
  wire rxLoad9 = rxStopSample && (nineBit || (mode == UBSC_MODE_UART8 && !multi_r));
  wire [7:0] rdMux =
    hit(regAddr, `UBSC_ADDR_SERIAL_CTRL) ? scRead :
    hit(regAddr, `UBSC_ADDR_RATE_RELOAD) ? reload_r :
    hit(regAddr, `UBSC_ADDR_RATE_CTRL) ? {4'h0, txBrg_r, rxBrg_r, speed_r, shiftBrg_r} :
    hit(regAddr, `UBSC_ADDR_SRC_SEL) ? {6'h00, txT2_r, rxT2_r} :
    hit(regAddr, `UBSC_ADDR_POWER_CTRL) ? {doubler_r, feSel_r, 6'h00} :
    hit(regAddr, `UBSC_ADDR_TX_DATA) ? rxSh_r[7:0] : `UBSC_RST_BYTE;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {modeHi_r, modeLo_r, multi_r, rxEn_r, tx9_r} <= 5'h00;
      {rx9_r, txDone_r, rxDone_r, fe_r} <= 4'h0;
      reload_r <= `UBSC_RST_BYTE;
      {txBrg_r, rxBrg_r, speed_r, shiftBrg_r} <= 4'h0;
      {txT2_r, rxT2_r, doubler_r, feSel_r} <= 4'h0;
      rdData_r <= `UBSC_RST_BYTE;
      shDiv_r <= 3'h0;
      m2Div_r <= 5'h00;
      t1Half_r <= 1'b0;
      timer2Fr_r <= 1'b0;
      txData_r <= `UBSC_RST_BYTE;
    end else begin
      shDiv_r <= shFixTick ? 3'h0 : shDiv_r + 3'h1;
      m2Div_r <= m2Tick ? 5'h00 : m2Div_r + 5'h01;
      if (timer1Ovf) begin
        t1Half_r <= ~t1Half_r;
      end
      timer2Fr_r <= (txSrc == UBSC_SRC_T2) || (rxSrc == UBSC_SRC_T2);
      rdData_r <= regRdStb ? rdMux : `UBSC_RST_BYTE;
      if (wrTx) begin
        txData_r <= regWrData;
      end
      if (wrSc) begin
        if (feSel_r) begin
          fe_r <= regWrData[`UBSC_SC_TOP];
        end else begin
          modeHi_r <= regWrData[`UBSC_SC_TOP];
        end
        modeLo_r <= regWrData[`UBSC_SC_MODE_LO];
        multi_r <= regWrData[`UBSC_SC_MULTI];
        rxEn_r <= regWrData[`UBSC_SC_RX_EN];
        tx9_r <= regWrData[`UBSC_SC_TX9];
        rx9_r <= regWrData[`UBSC_SC_RX9];
        txDone_r <= regWrData[`UBSC_SC_TX_DONE];
        rxDone_r <= regWrData[`UBSC_SC_RX_DONE];
      end
      // Hardware sets win over a same-cycle software clear.
      if (rxBadStop && feSel_r) begin
        fe_r <= 1'b1;
      end
      if (txSetDone || txSetDone0) begin
        txDone_r <= 1'b1;
      end
      if (rxSetDone) begin
        rxDone_r <= 1'b1;
      end
      if (rxLoad9) begin
        rx9_r <= nineBit ? rxSh_r[8] : rxS2_r;
      end
      if (regWrStb && hit(regAddr, `UBSC_ADDR_RATE_RELOAD)) begin
        reload_r <= regWrData;
      end
      if (regWrStb && hit(regAddr, `UBSC_ADDR_RATE_CTRL)) begin
        txBrg_r <= regWrData[`UBSC_RC_TX_BRG];
        rxBrg_r <= regWrData[`UBSC_RC_RX_BRG];
        speed_r <= regWrData[`UBSC_RC_SPEED];
        shiftBrg_r <= regWrData[`UBSC_RC_SHIFT_BRG];
      end
      if (regWrStb && hit(regAddr, `UBSC_ADDR_SRC_SEL)) begin
        txT2_r <= regWrData[`UBSC_SS_TX_T2];
        rxT2_r <= regWrData[`UBSC_SS_RX_T2];
      end
      if (regWrStb && hit(regAddr, `UBSC_ADDR_POWER_CTRL)) begin
        doubler_r <= regWrData[`UBSC_PC_DOUBLER];
        feSel_r <= regWrData[`UBSC_PC_FE_SEL];
      end
    end
  end
  // The shift clock pin idles high and falls for one system cycle per shift tick of the mode 0 transmit data phase.
  logic shClk_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shClk_r <= 1'b1;
    end else begin
      shClk_r <= !(isShift && txSt_r == UBSC_ST_DATA && shTick);
    end
  end
  assign regRdData = rdData_r;
  assign txdOut = txd_r;
  assign shiftClkOut = shClk_r;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_tx_src_brg: assert property (@(posedge clk) disable iff (!arst_n)
    txBrg_r |-> txVarTick == rate.brgTick) else $error("tx source wrong");
  a_rx_src_t2: assert property (@(posedge clk) disable iff (!arst_n)
    (!rxBrg_r && rxT2_r) |-> rxVarTick == timer2Ovf) else $error("rx source wrong");
  a_fe_sticky: assert property (@(posedge clk) disable iff (!arst_n)
    (fe_r && !wrSc) |=> fe_r) else $error("frame error lost");
  a_fe_set: assert property (@(posedge clk) disable iff (!arst_n)
    (rxBadStop && feSel_r) |=> fe_r) else $error("frame error not set");
  a_rx_off_idle: assert property (@(posedge clk) disable iff (!arst_n)
    (!rxEn_r && rxSt_r == UBSC_ST_IDLE) |=> rxSt_r == UBSC_ST_IDLE) else $error("rx ran");
  a_tx_done_set: assert property (@(posedge clk) disable iff (!arst_n)
    txSetDone |=> txDone_r && txSt_r == UBSC_ST_STOP) else $error("tx done late");
  a_rx_done_set: assert property (@(posedge clk) disable iff (!arst_n)
    rxSetDone |=> rxDone_r) else $error("rx done missed");
  a_t2_reload: assert property (@(posedge clk) disable iff (!arst_n)
    (txT2_r && !txBrg_r) |=> timer2ForceReload) else $error("t2 not forced");
  a_sc_read: assert property (@(posedge clk) disable iff (!arst_n)
    (regRdStb && hit(regAddr, `UBSC_ADDR_SERIAL_CTRL) && !wrSc && !rxSetDone && !txSetDone
     && !txSetDone0 && !rxBadStop && !rxLoad9)
    |=> regRdData == $past(scRead)) else $error("control read wrong");
  // A data write while idle outside mode 0 must put the start bit on the line at the next edge.
  sequence s_tx_load;
    (txSt_r == UBSC_ST_IDLE) && wrTx && !isShift;
  endsequence
  sequence s_tx_start_bit;
    (txSt_r == UBSC_ST_START) && !txd_r;
  endsequence
  a_tx_start_low: assert property (@(posedge clk) disable iff (!arst_n)
    s_tx_load |=> s_tx_start_bit) else $error("start bit missing");
  a_rx9_ninth: assert property (@(posedge clk) disable iff (!arst_n)
    (rxLoad9 && nineBit) |=> rx9_r == $past(rxSh_r[8])) else $error("ninth bit lost");
endmodule : ubsc_top

// >>> test/ubsc_peer.sv
// Remote serial peer that sends and samples asynchronous frames on the line.
`timescale 1ns/1ps
module ubsc_peer (
  input wire logic clk,
  input wire logic lineIn,
  output logic lineOut
);
  initial lineOut = 1'b1;

  // A frame is a low start bit, the data LSB first, then the stop level; idle is high.
  task automatic send(input logic [8:0] d, input int n, input logic stp, input int bc);
    @(posedge clk);
    lineOut <= 1'b0;
    repeat (bc) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      lineOut <= d[i];
      repeat (bc) @(posedge clk);
    end
    lineOut <= stp;
    repeat (bc) @(posedge clk);
    lineOut <= 1'b1;
    repeat (bc) @(posedge clk);
  endtask : send

  // Sampling on the falling edge keeps clear of the transmitter's own updates.
  task automatic recv(input int n, input int bc, output logic [8:0] d, output logic stp);
    int k;
    d = '0;
    k = 0;
    while (lineIn !== 1'b0 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    repeat (bc / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (bc) @(negedge clk);
      d[i] = lineIn;
    end
    repeat (bc) @(negedge clk);
    stp = lineIn;
  endtask : recv
endmodule : ubsc_peer

// >>> test/tb_uart_baud_select_and_serial_control.sv
// Self-checking bench for the serial rate selection and control block.
`timescale 1ns/1ps
module tb_uart_baud_select_and_serial_control import ubsc_pkg::*;;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic timer1Ovf = 1'b0;
  logic timer2Ovf = 1'b0;
  logic [7:0] regRdData;
  logic rxdPin, txdOut, shiftClkOut, timer2ForceReload;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int t1Cnt = 0;
  int t2Cnt = 0;

  ubsc_top i_dut (.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .timer1Ovf(timer1Ovf),
    .timer2Ovf(timer2Ovf), .rxdPin(rxdPin), .txdOut(txdOut), .shiftClkOut(shiftClkOut),
    .timer2ForceReload(timer2ForceReload));
  ubsc_peer i_peer (.clk(clk), .lineIn(txdOut), .lineOut(rxdPin));

  initial begin
    forever #5 clk = ~clk;
  end

  // Timers overflow every 3 and 5 cycles so each source yields its own bit length.
  always @(posedge clk) begin
    t1Cnt <= (t1Cnt == 2) ? 0 : t1Cnt + 1;
    t2Cnt <= (t2Cnt == 4) ? 0 : t2Cnt + 1;
    timer1Ovf <= (t1Cnt == 2);
    timer2Ovf <= (t2Cnt == 4);
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      $display("Error %0t: run did not finish", $time);
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chkn(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      miscompares++;
      $display("Error %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask : chkn

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    #1;
    d = regRdData;
  endtask : reg_rd

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    reg_rd(a, d);
    chk8(d, e);
  endtask : rd_chk

  // Length of data bit 0, a one between the low start bit and a low bit 1.
  task automatic bit_len(output int w);
    int k;
    k = 0;
    w = 0;
    while (txdOut !== 1'b0 && k < 100) begin
      @(negedge clk);
      k++;
    end
    while (txdOut !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    while (txdOut === 1'b1 && w < 2000) begin
      @(negedge clk);
      w++;
    end
  endtask : bit_len

  task automatic t_regs();
    logic [7:0] ad [6] = '{8'h98, 8'h9A, 8'h9B, 8'h9C, 8'h87, 8'h55};
    for (int i = 0; i < 6; i++) begin
      rd_chk(ad[i], 8'h00);
    end
    @(posedge clk);
    #1;
    chk8(regRdData, 8'h00);
    reg_wr(8'h9A, 8'h5A);
    reg_wr(8'h55, 8'hFF);
    rd_chk(8'h9A, 8'h5A);
    rd_chk(8'h55, 8'h00);
  endtask : t_regs

  task automatic t_tx_rate();
    logic [7:0] rc [8] = '{8'h0A, 8'h0A, 8'h0A, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] ss [8] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h01};
    logic [7:0] pc [8] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
    int len [8] = '{128, 128, 64, 768, 80, 96, 48, 96};
    logic frc [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    int w;
    reg_wr(8'h9A, 8'hFE);
    for (int i = 0; i < 8; i++) begin
      reg_wr(8'h98, 8'h40);
      reg_wr(8'h9B, rc[i]);
      reg_wr(8'h9C, ss[i]);
      reg_wr(8'h87, pc[i]);
      reg_wr(8'h99, 8'hA5);
      bit_len(w);
      chkn(w, len[i]);
      chk8({7'h00, timer2ForceReload}, {7'h00, frc[i]});
      repeat (7 * len[i] - 8) @(posedge clk);
      rd_chk(8'h98, 8'h40);
      repeat (len[i] / 2) @(posedge clk);
      rd_chk(8'h98, 8'h42);
      repeat (len[i]) @(posedge clk);
    end
  endtask : t_tx_rate

  task automatic t_mode2();
    logic [8:0] d;
    logic s;
    for (int i = 0; i < 2; i++) begin
      reg_wr(8'h87, i ? 8'h80 : 8'h00);
      reg_wr(8'h98, i ? 8'h80 : 8'h88);
      fork
        i_peer.recv(9, i ? 16 : 32, d, s);
        reg_wr(8'h99, 8'hA5);
      join
      chk8(d[7:0], 8'hA5);
      chk8({7'h00, d[8]}, i ? 8'h00 : 8'h01);
      chk8({7'h00, s}, 8'h01);
      rd_chk(8'h98, i ? 8'h82 : 8'h8A);
      repeat (32) @(posedge clk);
    end
  endtask : t_mode2

  task automatic t_mode0();
    int gap;
    int n;
    int k;
    reg_wr(8'h87, 8'h00);
    for (int i = 0; i < 2; i++) begin
      reg_wr(8'h9B, i ? 8'h03 : 8'h02);
      reg_wr(8'h98, 8'h00);
      reg_wr(8'h99, 8'h3C);
      k = 0;
      gap = 0;
      n = 1;
      while (shiftClkOut !== 1'b0 && k < 100) begin
        @(negedge clk);
        k++;
      end
      for (k = 0; k < 120; k++) begin
        @(negedge clk);
        if (shiftClkOut === 1'b0) begin
          n++;
          if (n == 2) gap = k + 1;
        end
      end
      chkn(gap, i ? 8 : 6);
      chkn(n, 8);
      rd_chk(8'h98, 8'h02);
    end
    reg_wr(8'h9B, 8'h02);
    reg_wr(8'h98, 8'h10);
    repeat (30) @(posedge clk);
    rd_chk(8'h98, 8'h10);
    repeat (30) @(posedge clk);
    rd_chk(8'h98, 8'h11);
    reg_wr(8'h98, 8'h00);
  endtask : t_mode0

  task automatic t_rx();
    logic [7:0] ct [6] = '{8'h50, 8'h40, 8'hD0, 8'hD0, 8'hF0, 8'hF0};
    logic [8:0] dt [6] = '{9'h03C, 9'h03C, 9'h0A5, 9'h1A5, 9'h0A5, 9'h1C3};
    logic [7:0] et [6] = '{8'h55, 8'h40, 8'hD1, 8'hD5, 8'hF0, 8'hF5};
    reg_wr(8'h9B, 8'h06);
    for (int i = 0; i < 6; i++) begin
      reg_wr(8'h98, ct[i]);
      i_peer.send(dt[i], i < 2 ? 8 : 9, 1'b1, 128);
      rd_chk(8'h98, et[i]);
      if (et[i][0]) rd_chk(8'h99, dt[i][7:0]);
    end
  endtask : t_rx

  // Mode high is rewritten with the access select low, so the error flag is left alone.
  task automatic t_frame();
    logic [7:0] d;
    reg_wr(8'h98, 8'h50);
    reg_wr(8'h87, 8'h40);
    i_peer.send(9'h03C, 8, 1'b0, 128);
    reg_rd(8'h98, d);
    chk8(d & 8'h80, 8'h80);
    reg_wr(8'h87, 8'h00);
    reg_wr(8'h98, 8'h50);
    reg_wr(8'h87, 8'h40);
    i_peer.send(9'h03C, 8, 1'b1, 128);
    reg_rd(8'h98, d);
    chk8(d & 8'h85, 8'h85);
    reg_wr(8'h98, 8'h50);
    rd_chk(8'h98, 8'h50);
    reg_wr(8'h87, 8'h00);
    reg_wr(8'h98, 8'hC0);
    rd_chk(8'h98, 8'hC0);
    reg_wr(8'h87, 8'h40);
    rd_chk(8'h98, 8'h40);
  endtask : t_frame

  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_tx_rate();
    t_mode2();
    t_mode0();
    t_rx();
    t_frame();
    give_verdict();
  end
endmodule : tb_uart_baud_select_and_serial_control
